/* File: core/otfs_defines.vh */
// register offsets, reset values, selection codes and fixed ratios of the output terminal selector
// assumes a 32-bit AXI4-Lite register bus with byte addresses
`ifndef OTFS_DEFINES_VH
`define OTFS_DEFINES_VH

// register byte offsets
`define OTFS_REG_SEL_RUN     8'h00
`define OTFS_REG_SEL_RELAY   8'h04
`define OTFS_REG_SEL_SO      8'h08
`define OTFS_REG_REMOTE      8'h0C
`define OTFS_REG_OC_THRESH   8'h10
`define OTFS_REG_OC_HOLD     8'h14
`define OTFS_REG_ZC_THRESH   8'h18
`define OTFS_REG_ZC_HOLD     8'h1C
`define OTFS_REG_MAINT_ALARM 8'h20
`define OTFS_REG_STATUS      8'h24
`define OTFS_REG_CLEAR       8'h28

// default selections after reset
`define OTFS_RST_SEL_RUN     8'h00
`define OTFS_RST_SEL_RELAY   8'h63
`define OTFS_RST_SEL_SO      8'h50

// code ranges
`define OTFS_CODE_NEG_BASE   8'h64
`define OTFS_CODE_LIMIT      8'hC8

// condition codes (source form)
`define OTFS_C_RUNNING       0
`define OTFS_C_UP_TO_SPEED   1
`define OTFS_C_OVERLOAD      3
`define OTFS_C_FREQ_DETECT   4
`define OTFS_C_BRAKE_PRE     7
`define OTFS_C_THERMAL_PRE   8
`define OTFS_C_READY         11
`define OTFS_C_OVERCURRENT   12
`define OTFS_C_ZERO_CURRENT  13
`define OTFS_C_LOOP_LOWER    14
`define OTFS_C_LOOP_UPPER    15
`define OTFS_C_LOOP_FORWARD  16
`define OTFS_C_FAN_FAULT     25
`define OTFS_C_HEATSINK_PRE  26
`define OTFS_C_MAINS_LOSS    46
`define OTFS_C_LOOP_ACTIVE   47
`define OTFS_C_RETRY         64
`define OTFS_C_LOOP_SLEEP    70
`define OTFS_C_SAFETY_STOP   80
`define OTFS_C_SAFETY_OK     81
`define OTFS_C_LIFE_ALARM    90
`define OTFS_C_POWER_OFF     91
`define OTFS_C_AVG_PULSE     93
`define OTFS_C_MAINT         95
`define OTFS_C_REMOTE        96
`define OTFS_C_MINOR_FAULT   98
`define OTFS_C_MAJOR_FAULT   99
`define OTFS_CODE_AVG_POS    8'h5D
`define OTFS_CODE_AVG_NEG    8'hC1

// prealarm ratio 85 % as 17/20
`define OTFS_PRE_NUM         5'h11
`define OTFS_PRE_DEN         5'h14

// bus answers
`define OTFS_RESP_OKAY       2'h0
`define OTFS_RESP_SLVERR     2'h2

`endif

/* File: core/otfs_term_sel.v */
// one output terminal selector: code to condition, polarity, registered level
// assumes the condition vector and code are synchronous to aclk
`include "otfs_defines.vh"

module otfs_term_sel #(
	parameter NCOND = 100
) (
	input  wire             aclk,
	input  wire             aresetn,
	input  wire [7:0]       code,
	input  wire [NCOND-1:0] cond,
	output reg              conduct
);

	reg       valid;
	reg       neg;
	reg [7:0] base;

	always @* begin
		valid = 1'b1;
		neg = 1'b0;
		base = code;
		if (code >= `OTFS_CODE_LIMIT) begin
			valid = 1'b0;
			base = 8'h00;
		end else if (code >= `OTFS_CODE_NEG_BASE) begin
			neg = 1'b1;
			base = code - `OTFS_CODE_NEG_BASE;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn)
			conduct <= 1'b0;
		else
			conduct <= valid & (cond[base[6:0]] ^ neg);
	end

endmodule // otfs_term_sel

/* File: core/otfs_top.v */
// output terminal function selector: register file, condition logic, three terminals
// assumes status inputs synchronous to aclk and an AXI4-Lite master on the bus side
//
// What this block does
// - codes 8/108 drive thermal prealarm at 85 % of overload trip level.
// - codes 11/111 drive operation ready, also true while running.
// - codes 12/112 flag current above threshold for longer than hold time.
// - codes 13/113 flag power below threshold for longer than hold time.
// - codes 14/114 flag feedback below lower limit; 15/115 above upper limit.
// - codes 16/116 flag forward rotation commanded by regulator.
// - codes 25/125 flag cooling fan fault.
// - codes 26/126 flag heatsink at about 85 % of overheat temperature.
// - codes 46/146 flag mains-loss deceleration, latched until released.
// - codes 47/147 flag closed-loop regulation active.
// - codes 64/164 flag fault retry under way.
// - codes 70/170 flag regulator sleep in effect.
// - codes 80/180 flag safety stop holding output off.
// - codes 81/181 flag absence of safety circuit fault.
// - codes 90/190 drive OR of four end-of-life warnings.
// - codes 91/191 flag internal circuit or wiring fault.
// - codes 93/193 output pulse train; refused on relay terminal.
// - codes 95/195 flag maintenance counter at or above alarm setting.
// - codes 96/196 follow a software written remote bit.
// - codes 98/198 flag fan failure or communication warning.
// - codes 99/199 drive major fault alarm, cleared only by fault reset or clear register bit 1.
// - up-to-speed passes unfiltered; steady input gives steady terminal.
// - codes 0-99 positive polarity, 100-199 same condition negative.
// - true condition conducts on positive code, not on negative code.
// - terminals select independently; one condition may feed several.
// - reset selections: first 0, relay 99, second 80.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`include "otfs_defines.vh"

module otfs_top #(
	parameter DW = 16
) (
	input  wire          aclk,
	input  wire          aresetn,
	input  wire [7:0]    s_axi_awaddr,
	input  wire          s_axi_awvalid,
	output reg           s_axi_awready,
	input  wire [31:0]   s_axi_wdata,
	input  wire [3:0]    s_axi_wstrb,
	input  wire          s_axi_wvalid,
	output reg           s_axi_wready,
	output reg  [1:0]    s_axi_bresp,
	output reg           s_axi_bvalid,
	input  wire          s_axi_bready,
	input  wire [7:0]    s_axi_araddr,
	input  wire          s_axi_arvalid,
	output reg           s_axi_arready,
	output reg  [31:0]   s_axi_rdata,
	output reg  [1:0]    s_axi_rresp,
	output reg           s_axi_rvalid,
	input  wire          s_axi_rready,
	input  wire          drive_running,
	input  wire          up_to_speed_flag,
	input  wire          overload_alarm,
	input  wire          freq_detect,
	input  wire          brake_prealarm,
	input  wire [DW-1:0] overload_accum,
	input  wire [DW-1:0] overload_trip_level,
	input  wire          start_possible,
	input  wire [DW-1:0] output_current,
	input  wire [DW-1:0] output_power,
	input  wire [DW-1:0] loop_feedback,
	input  wire [DW-1:0] loop_lower_limit,
	input  wire [DW-1:0] loop_upper_limit,
	input  wire          loop_forward_flag,
	input  wire          loop_active,
	input  wire          loop_sleep,
	input  wire          fan_fault,
	input  wire [DW-1:0] heatsink_temp,
	input  wire [DW-1:0] heatsink_trip_temp,
	input  wire          mains_loss_decel,
	input  wire          mains_loss_release,
	input  wire          retry_active,
	input  wire          safety_stop,
	input  wire          safety_circuit_fault,
	input  wire [3:0]    life_warnings,
	input  wire          power_off_fault,
	input  wire          current_average_pulse,
	input  wire [DW-1:0] maint_counter,
	input  wire          comm_warning,
	input  wire          protective_trip,
	input  wire          fault_reset,
	output wire          run_terminal,
	output wire          relay_contact_terminal,
	output wire          so_terminal
);

	reg  [7:0]    sel_run;
	reg  [7:0]    sel_relay;
	reg  [7:0]    sel_so;
	reg  [2:0]    remote_out;
	reg  [DW-1:0] oc_thresh;
	reg  [DW-1:0] oc_hold;
	reg  [DW-1:0] zc_thresh;
	reg  [DW-1:0] zc_hold;
	reg  [DW-1:0] maint_alarm;
	reg           aw_full;
	reg           w_full;
	reg  [7:0]    aw_addr;
	reg  [31:0]   w_data;
	reg  [3:0]    w_strb;
	reg  [DW-1:0] oc_cnt;
	reg  [DW-1:0] zc_cnt;
	reg           overcurrent_detect;
	reg           zero_current_detect;
	reg           thermal_prealarm;
	reg           heatsink_prealarm;
	reg           mains_loss_decel_flag;
	reg           major_fault_alarm;
	reg           life_alarm;
	reg           maintenance_flag;
	reg           minor_fault;
	reg  [99:0]   cond;
	reg  [31:0]   rd_mux;
	reg           rd_err;
	reg  [7:0]    next_code;
	reg           next_code_ok;
	wire [31:0]   wmask;
	wire [DW-1:0] wval;
	wire          do_write;
	wire [DW+4:0] acc_x;
	wire [DW+4:0] trip_x;
	wire [DW+4:0] hs_x;
	wire [DW+4:0] hs_trip_x;
	wire          oc_above;
	wire          zc_below;
	wire          clr_mains;
	wire          clr_fault;
	wire [2:0]    term_level;

	assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
	assign do_write = aw_full & w_full & ~s_axi_bvalid;
	assign acc_x = {5'h00, overload_accum};
	assign trip_x = {5'h00, overload_trip_level};
	assign hs_x = {5'h00, heatsink_temp};
	assign hs_trip_x = {5'h00, heatsink_trip_temp};
	assign oc_above = output_current > oc_thresh;
	assign zc_below = output_power < zc_thresh;
	assign clr_mains = mains_loss_release |
		(do_write && aw_addr == `OTFS_REG_CLEAR && w_strb[0] && w_data[0]);
	assign clr_fault = fault_reset |
		(do_write && aw_addr == `OTFS_REG_CLEAR && w_strb[0] && w_data[1]);
	assign wval = w_data[DW-1:0] & wmask[DW-1:0];

	// byte-merged selection code and its legality for the addressed terminal
	always @* begin
		next_code = w_strb[0] ? w_data[7:0] : 8'h00;
		next_code_ok = 1'b0;
		case (aw_addr)
			`OTFS_REG_SEL_RUN: begin
				next_code = w_strb[0] ? w_data[7:0] : sel_run;
				next_code_ok = 1'b1;
			end
			`OTFS_REG_SEL_RELAY: begin
				next_code = w_strb[0] ? w_data[7:0] : sel_relay;
				next_code_ok = next_code != `OTFS_CODE_AVG_POS && next_code != `OTFS_CODE_AVG_NEG;
			end
			`OTFS_REG_SEL_SO: begin
				next_code = w_strb[0] ? w_data[7:0] : sel_so;
				next_code_ok = 1'b1;
			end
			default: next_code_ok = 1'b0;
		endcase
		if (next_code >= `OTFS_CODE_LIMIT)
			next_code_ok = 1'b0;
	end

	// write channel: address and data taken in either order, answer after both
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `OTFS_RESP_OKAY;
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full <= 1'b1;
				aw_addr <= {s_axi_awaddr[7:2], 2'b00};
				s_axi_awready <= 1'b0;
			end else if (!aw_full && !s_axi_bvalid)
				s_axi_awready <= 1'b1;
			if (s_axi_wvalid && s_axi_wready) begin
				w_full <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end else if (!w_full && !s_axi_bvalid)
				s_axi_wready <= 1'b1;
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				case (aw_addr)
					`OTFS_REG_SEL_RUN, `OTFS_REG_SEL_RELAY, `OTFS_REG_SEL_SO:
						s_axi_bresp <= next_code_ok ? `OTFS_RESP_OKAY : `OTFS_RESP_SLVERR;
					`OTFS_REG_REMOTE, `OTFS_REG_OC_THRESH, `OTFS_REG_OC_HOLD, `OTFS_REG_ZC_THRESH,
					`OTFS_REG_ZC_HOLD, `OTFS_REG_MAINT_ALARM, `OTFS_REG_STATUS, `OTFS_REG_CLEAR:
						s_axi_bresp <= `OTFS_RESP_OKAY;
					default: s_axi_bresp <= `OTFS_RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_full <= 1'b0;
				w_full <= 1'b0;
			end
		end
	end

	// software-written registers
	always @(posedge aclk) begin
		if (!aresetn) begin
			sel_run <= `OTFS_RST_SEL_RUN;
			sel_relay <= `OTFS_RST_SEL_RELAY;
			sel_so <= `OTFS_RST_SEL_SO;
			remote_out <= 3'h0;
			oc_thresh <= {DW{1'b0}};
			oc_hold <= {DW{1'b0}};
			zc_thresh <= {DW{1'b0}};
			zc_hold <= {DW{1'b0}};
			maint_alarm <= {DW{1'b1}};
		end else if (do_write) begin
			case (aw_addr)
				`OTFS_REG_SEL_RUN:
					if (next_code_ok)
						sel_run <= next_code;
				`OTFS_REG_SEL_RELAY:
					if (next_code_ok)
						sel_relay <= next_code;
				`OTFS_REG_SEL_SO:
					if (next_code_ok)
						sel_so <= next_code;
				`OTFS_REG_REMOTE:
					if (w_strb[0])
						remote_out <= w_data[2:0];
				`OTFS_REG_OC_THRESH: oc_thresh <= (oc_thresh & ~wmask[DW-1:0]) | wval;
				`OTFS_REG_OC_HOLD: oc_hold <= (oc_hold & ~wmask[DW-1:0]) | wval;
				`OTFS_REG_ZC_THRESH: zc_thresh <= (zc_thresh & ~wmask[DW-1:0]) | wval;
				`OTFS_REG_ZC_HOLD: zc_hold <= (zc_hold & ~wmask[DW-1:0]) | wval;
				`OTFS_REG_MAINT_ALARM: maint_alarm <= (maint_alarm & ~wmask[DW-1:0]) | wval;
				default: remote_out <= remote_out;
			endcase
		end
	end

	// read data mux
	always @* begin
		rd_mux = 32'h00000000;
		rd_err = 1'b0;
		case ({s_axi_araddr[7:2], 2'b00})
			`OTFS_REG_SEL_RUN: rd_mux[7:0] = sel_run;
			`OTFS_REG_SEL_RELAY: rd_mux[7:0] = sel_relay;
			`OTFS_REG_SEL_SO: rd_mux[7:0] = sel_so;
			`OTFS_REG_REMOTE: rd_mux[2:0] = remote_out;
			`OTFS_REG_OC_THRESH: rd_mux[DW-1:0] = oc_thresh;
			`OTFS_REG_OC_HOLD: rd_mux[DW-1:0] = oc_hold;
			`OTFS_REG_ZC_THRESH: rd_mux[DW-1:0] = zc_thresh;
			`OTFS_REG_ZC_HOLD: rd_mux[DW-1:0] = zc_hold;
			`OTFS_REG_MAINT_ALARM: rd_mux[DW-1:0] = maint_alarm;
			`OTFS_REG_STATUS:
				rd_mux[10:0] = {maintenance_flag, life_alarm, major_fault_alarm, mains_loss_decel_flag,
					heatsink_prealarm, zero_current_detect, overcurrent_detect, thermal_prealarm, term_level};
			`OTFS_REG_CLEAR: rd_mux = 32'h00000000;
			default: rd_err = 1'b1;
		endcase
	end

	// read channel: answer one cycle after the address is taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `OTFS_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= rd_err ? `OTFS_RESP_SLVERR : `OTFS_RESP_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end else if (!s_axi_rvalid)
			s_axi_arready <= 1'b1;
	end

	// hold-time detectors, saturating counters
	always @(posedge aclk) begin
		if (!aresetn) begin
			oc_cnt <= {DW{1'b0}};
			zc_cnt <= {DW{1'b0}};
			overcurrent_detect <= 1'b0;
			zero_current_detect <= 1'b0;
		end else begin
			if (!oc_above)
				oc_cnt <= {DW{1'b0}};
			else if (oc_cnt != {DW{1'b1}})
				oc_cnt <= oc_cnt + {{(DW-1){1'b0}}, 1'b1};
			if (!zc_below)
				zc_cnt <= {DW{1'b0}};
			else if (zc_cnt != {DW{1'b1}})
				zc_cnt <= zc_cnt + {{(DW-1){1'b0}}, 1'b1};
			overcurrent_detect <= oc_above && oc_cnt >= oc_hold;
			zero_current_detect <= zc_below && zc_cnt >= zc_hold;
		end
	end

	// prealarms, latches and fault summaries
	always @(posedge aclk) begin
		if (!aresetn) begin
			thermal_prealarm <= 1'b0;
			heatsink_prealarm <= 1'b0;
			mains_loss_decel_flag <= 1'b0;
			major_fault_alarm <= 1'b0;
			life_alarm <= 1'b0;
			maintenance_flag <= 1'b0;
			minor_fault <= 1'b0;
		end else begin
			thermal_prealarm <= acc_x * `OTFS_PRE_DEN >= trip_x * `OTFS_PRE_NUM;
			heatsink_prealarm <= hs_x * `OTFS_PRE_DEN >= hs_trip_x * `OTFS_PRE_NUM;
			if (mains_loss_decel)
				mains_loss_decel_flag <= 1'b1;
			else if (clr_mains)
				mains_loss_decel_flag <= 1'b0;
			if (protective_trip)
				major_fault_alarm <= 1'b1;
			else if (clr_fault)
				major_fault_alarm <= 1'b0;
			life_alarm <= |life_warnings;
			maintenance_flag <= maint_counter >= maint_alarm;
			minor_fault <= fan_fault | comm_warning;
		end
	end

	// condition vector indexed by source code
	always @* begin
		cond = 100'h0;
		cond[`OTFS_C_RUNNING] = drive_running;
		cond[`OTFS_C_UP_TO_SPEED] = up_to_speed_flag;
		cond[`OTFS_C_OVERLOAD] = overload_alarm;
		cond[`OTFS_C_FREQ_DETECT] = freq_detect;
		cond[`OTFS_C_BRAKE_PRE] = brake_prealarm;
		cond[`OTFS_C_THERMAL_PRE] = thermal_prealarm;
		cond[`OTFS_C_READY] = start_possible | drive_running;
		cond[`OTFS_C_OVERCURRENT] = overcurrent_detect;
		cond[`OTFS_C_ZERO_CURRENT] = zero_current_detect;
		cond[`OTFS_C_LOOP_LOWER] = loop_feedback < loop_lower_limit;
		cond[`OTFS_C_LOOP_UPPER] = loop_feedback > loop_upper_limit;
		cond[`OTFS_C_LOOP_FORWARD] = loop_forward_flag;
		cond[`OTFS_C_FAN_FAULT] = fan_fault;
		cond[`OTFS_C_HEATSINK_PRE] = heatsink_prealarm;
		cond[`OTFS_C_MAINS_LOSS] = mains_loss_decel_flag;
		cond[`OTFS_C_LOOP_ACTIVE] = loop_active;
		cond[`OTFS_C_RETRY] = retry_active;
		cond[`OTFS_C_LOOP_SLEEP] = loop_sleep;
		cond[`OTFS_C_SAFETY_STOP] = safety_stop;
		cond[`OTFS_C_SAFETY_OK] = ~safety_circuit_fault;
		cond[`OTFS_C_LIFE_ALARM] = life_alarm;
		cond[`OTFS_C_POWER_OFF] = power_off_fault;
		cond[`OTFS_C_AVG_PULSE] = current_average_pulse;
		cond[`OTFS_C_MAINT] = maintenance_flag;
		cond[`OTFS_C_MINOR_FAULT] = minor_fault;
		cond[`OTFS_C_MAJOR_FAULT] = major_fault_alarm;
	end

	// one independent selector per terminal, each with its own remote bit
	otfs_term_sel #(.NCOND(100)) u_sel_run (
		.aclk    (aclk),
		.aresetn (aresetn),
		.code    (sel_run),
		.cond    (cond | ({99'h0, remote_out[0]} << `OTFS_C_REMOTE)),
		.conduct (term_level[0])
	);

	otfs_term_sel #(.NCOND(100)) u_sel_relay (
		.aclk    (aclk),
		.aresetn (aresetn),
		.code    (sel_relay),
		.cond    (cond | ({99'h0, remote_out[1]} << `OTFS_C_REMOTE)),
		.conduct (term_level[1])
	);

	otfs_term_sel #(.NCOND(100)) u_sel_so (
		.aclk    (aclk),
		.aresetn (aresetn),
		.code    (sel_so),
		.cond    (cond | ({99'h0, remote_out[2]} << `OTFS_C_REMOTE)),
		.conduct (term_level[2])
	);

	assign run_terminal = term_level[0];
	assign relay_contact_terminal = term_level[1];
	assign so_terminal = term_level[2];

endmodule // otfs_top

/* File: tb/otfs_ext_equip.sv */
// external equipment model: reads the three terminal states on the drive clock
// assumes 1 on a terminal means it conducts; it only reads, never drives
module otfs_ext_equip (
	input  wire logic       aclk,
	input  wire logic       run_terminal,
	input  wire logic       relay_contact_terminal,
	input  wire logic       so_terminal,
	output logic      [2:0] seen
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge aclk)
		seen <= {run_terminal, relay_contact_terminal, so_terminal};
endmodule // otfs_ext_equip

/* File: tb/otfs_top_assertions.sv */
// checker for the output terminal selector: reset levels, default selections, bus refusals
// assumes it is bound to otfs_top and sees only its ports
`include "otfs_defines.vh"
module otfs_chk (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        drive_running,
	input wire logic        safety_stop,
	input wire logic        protective_trip,
	input wire logic        run_terminal,
	input wire logic        relay_contact_terminal,
	input wire logic        so_terminal
);
	timeunit 1ns;
	timeprecision 1ps;
	logic dflt;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// no write address taken since reset, so selections untouched
	always_ff @(posedge aclk)
		if (!aresetn)
			dflt <= 1'b1;
		else if (s_axi_awvalid && s_axi_awready)
			dflt <= 1'b0;
	sequence s_wtake;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_slverr;
		##[1:3] s_axi_bvalid && s_axi_bresp == `OTFS_RESP_SLVERR;
	endsequence
	property p_rst_idle;
		$rose(aresetn) |-> !run_terminal && !relay_contact_terminal && !so_terminal
			##1 run_terminal == $past(drive_running);
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("terminal active after reset");
	property p_run_dflt;
		dflt && $past(aresetn) |=> run_terminal == $past(drive_running);
	endproperty
	a_run_dflt: assert property (p_run_dflt) else $error("run terminal wrong default");
	property p_so_dflt;
		dflt && $past(aresetn) |=> so_terminal == $past(safety_stop);
	endproperty
	a_so_dflt: assert property (p_so_dflt) else $error("so terminal wrong default");
	property p_relay_dflt;
		dflt && protective_trip |-> ##[1:3] relay_contact_terminal;
	endproperty
	a_relay_dflt: assert property (p_relay_dflt) else $error("relay missed alarm");
	property p_refuse_pulse;
		s_wtake ##0 (s_axi_awaddr == `OTFS_REG_SEL_RELAY && (s_axi_wdata[7:0] == `OTFS_CODE_AVG_POS
			|| s_axi_wdata[7:0] == `OTFS_CODE_AVG_NEG)) |-> s_slverr;
	endproperty
	a_refuse_pulse: assert property (p_refuse_pulse) else $error("pulse code taken on relay");
	property p_refuse_code;
		s_wtake ##0 (s_axi_awaddr <= `OTFS_REG_SEL_SO && s_axi_wdata[7:0] >= `OTFS_CODE_LIMIT) |-> s_slverr;
	endproperty
	a_refuse_code: assert property (p_refuse_code) else $error("out of range code taken");
	property p_wresp;
		s_wtake |=> (!s_axi_awready && !s_axi_wready) throughout (##[0:2] s_axi_bvalid);
	endproperty
	a_wresp: assert property (p_wresp) else $error("write response late");
	property p_bbusy;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_bbusy: assert property (p_bbusy) else $error("write ready during response");
	property p_rbusy;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_rbusy: assert property (p_rbusy) else $error("read ready during response");
endmodule // otfs_chk
bind otfs_top otfs_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.drive_running(drive_running), .safety_stop(safety_stop), .protective_trip(protective_trip),
	.run_terminal(run_terminal), .relay_contact_terminal(relay_contact_terminal), .so_terminal(so_terminal));

/* File: tb/tb_top.sv */
// testbench: status inputs and AXI4-Lite accesses against the terminal selector
// assumes the design, the equipment model and the checker are compiled first
`include "otfs_defines.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 1'b0, aresetn = 1'b0, mlr = 1'b0, frst = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [15:0] cur = 16'h0000, fb = 16'h000A;
	logic        lv [100] = '{default: 1'b0};
	wire         awready, wready, bvalid, arready, rvalid;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire  [2:0]  term, seen;
	int          failures = 0, cmp_count = 0;
	// order keeps leftovers of earlier codes away from ready and minor fault
	byte unsigned codes [28] = '{11, 98, 0, 1, 3, 4, 7, 8, 12, 13, 14, 15, 16, 25, 26, 46, 47,
		64, 70, 80, 81, 90, 91, 93, 95, 96, 99, 50}; // as listed
	otfs_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .drive_running(lv[0]),
		.up_to_speed_flag(lv[1]), .overload_alarm(lv[3]), .freq_detect(lv[4]), .brake_prealarm(lv[7]),
		.overload_accum(lv[8] ? 16'h0011 : 16'h0010), .overload_trip_level(16'h0014), .start_possible(lv[11]),
		.output_current(cur), .output_power(lv[13] ? 16'h0009 : 16'h000A), .loop_feedback(fb),
		.loop_lower_limit(16'h0005), .loop_upper_limit(16'h0014), .loop_forward_flag(lv[16]),
		.loop_active(lv[47]), .loop_sleep(lv[70]), .fan_fault(lv[25]), .heatsink_temp(lv[26] ? 16'h0011 : 16'h0010),
		.heatsink_trip_temp(16'h0014), .mains_loss_decel(lv[46]), .mains_loss_release(mlr), .retry_active(lv[64]),
		.safety_stop(lv[80]), .safety_circuit_fault(!lv[81]), .life_warnings({lv[90], 3'h0}),
		.power_off_fault(lv[91]), .current_average_pulse(lv[93]), .maint_counter(lv[95] ? 16'hFFFF : 16'hFFFE),
		.comm_warning(lv[98]), .protective_trip(lv[99]), .fault_reset(frst), .run_terminal(term[2]),
		.relay_contact_terminal(term[1]), .so_terminal(term[0]));
	otfs_ext_equip ext (.aclk(aclk), .run_terminal(term[2]), .relay_contact_terminal(term[1]),
		.so_terminal(term[0]), .seen(seen));
	initial begin
		forever #25 aclk = ~aclk;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// one bus access: write when w is set, else read expecting data d
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		araddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= {3{w}};
		{arvalid, rready} <= {2{!w}};
		do begin
			@(posedge aclk);
			n++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (arready)
				arvalid <= 1'b0;
		end while (!(w ? bvalid : rvalid) && n < 100);
		{bready, rready} <= 2'b00;
		failures += (n >= 100);
		if (n >= 100)
			results();
		chk(w ? bresp : rresp, r);
		if (!w)
			chk(rdata, d);
	endtask
	task automatic cond(input int c, input logic v);
		case (c)
			12: cur <= {15'h0, v};
			14: fb <= v ? 16'h0004 : 16'h0005;
			15: fb <= v ? 16'h0015 : 16'h0014;
			46: {lv[46], mlr} <= {v, !v};
			96: acc(1'b1, `OTFS_REG_REMOTE, {29'h0, {3{v}}}, 2'h0);
			99: {lv[99], frst} <= {v, !v};
			default: lv[c] <= v;
		endcase
	endtask
	initial begin
		logic [2:0] e;
		repeat (20) @(posedge aclk);
		chk(term, 3'b000);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(term, 3'b000);
		{lv[0], lv[80], lv[99]} <= 3'b111;
		repeat (4) @(posedge aclk);
		chk(term, 3'b111);
		{lv[0], lv[99]} <= 2'b00;
		repeat (4) @(posedge aclk);
		chk(term, 3'b011);
		{lv[80], frst} <= 2'b01;
		repeat (4) @(posedge aclk);
		chk(term, 3'b000);
		$display("test defaults done");
		acc(1'b0, `OTFS_REG_SEL_RUN, 32'h0, 2'h0);
		acc(1'b0, `OTFS_REG_SEL_RELAY, 32'h63, 2'h0);
		acc(1'b0, `OTFS_REG_SEL_SO, 32'h50, 2'h0);
		acc(1'b0, 8'h40, 32'h0, 2'h2);
		acc(1'b1, `OTFS_REG_SEL_SO, 32'hC8, 2'h2);
		acc(1'b1, `OTFS_REG_SEL_RELAY, 32'h5D, 2'h2);
		acc(1'b0, `OTFS_REG_SEL_SO, 32'h50, 2'h0);
		acc(1'b0, `OTFS_REG_SEL_RELAY, 32'h63, 2'h0);
		acc(1'b1, `OTFS_REG_ZC_THRESH, 32'hA, 2'h0);
		$display("test registers done");
		foreach (codes[i]) begin
			cond(codes[i], 1'b0);
			acc(1'b1, `OTFS_REG_SEL_RUN, codes[i], 2'h0);
			acc(1'b1, `OTFS_REG_SEL_RELAY, codes[i] + 100, codes[i] == 93 ? 2'h2 : 2'h0);
			acc(1'b1, `OTFS_REG_SEL_SO, codes[i], 2'h0);
			for (int v = 0; v < 2; v++) begin
				cond(codes[i], v[0]);
				repeat (4) @(posedge aclk);
				// code 50 has no condition; relay conducts on its negative code 150
				e = codes[i] == 50 ? 3'b010 : {v[0], codes[i] == 93 ? 1'b0 : !v[0], v[0]};
				chk(seen, e);
			end
		end
		$display("test codes done");
		acc(1'b1, `OTFS_REG_SEL_RUN, 32'h2E, 2'h0);
		cond(46, 1'b1);
		repeat (4) @(posedge aclk);
		lv[46] <= 1'b0;
		repeat (4) @(posedge aclk);
		chk(seen[2], 1'b1);
		acc(1'b1, `OTFS_REG_CLEAR, 32'h1, 2'h0);
		repeat (4) @(posedge aclk);
		chk(seen[2], 1'b0);
		acc(1'b1, `OTFS_REG_SEL_RUN, 32'hB, 2'h0);
		{lv[11], lv[0]} <= 2'b01;
		repeat (4) @(posedge aclk);
		chk(seen[2], 1'b1);
		acc(1'b1, `OTFS_REG_OC_THRESH, 32'h64, 2'h0);
		acc(1'b1, `OTFS_REG_OC_HOLD, 32'h3, 2'h0);
		acc(1'b1, `OTFS_REG_SEL_RUN, 32'hC, 2'h0);
		cur <= 16'h0064;
		repeat (8) @(posedge aclk);
		chk(seen[2], 1'b0);
		cur <= 16'h0065;
		repeat (4) @(posedge aclk);
		chk(seen[2], 1'b0);
		repeat (5) @(posedge aclk);
		chk(seen[2], 1'b1);
		$display("test latch ready hold done");
		results();
	end
endmodule // tb_top
